// file: rtl/pmt_defines.vh
// Register map, field positions and reset values of the period timer
`ifndef PMT_DEFINES_VH
`define PMT_DEFINES_VH
`define PMT_ADDR_W          12
`define PMT_OFS_CONTROL     12'h000
`define PMT_OFS_COUNT       12'h004
`define PMT_OFS_PERIOD      12'h008
`define PMT_OFS_FLAG        12'h00c
`define PMT_PS_LO           0
`define PMT_PS_HI           1
`define PMT_RUN_BIT         2
`define PMT_POST_LO         3
`define PMT_POST_HI         6
`define PMT_CTRL_MASK       8'h7f
`define PMT_CTRL_RST        8'h00
`define PMT_COUNT_RST       8'h00
`define PMT_PERIOD_RST      8'hff
`define PMT_FLAG_BIT        0
`define PMT_INSTR_DIV       2'h3
`define PMT_PRE_DIV1        4'h0
`define PMT_PRE_DIV4        4'h3
`define PMT_PRE_DIV16       4'hf
`define PMT_PRE_SEL_DIV1    2'h0
`define PMT_PRE_SEL_DIV4    2'h1
`endif

// file: rtl/pmt_prescaler.v
// Instruction clock divider and selectable 1/4/16 prescaler
`include "pmt_defines.vh"
module pmt_prescaler (
  input  wire       core_clk,
  input  wire       sys_rst,
  input  wire       clk_en,
  input  wire       run,
  input  wire       clear,
  input  wire [1:0] sel,
  output reg        tick_ff
);
  reg  [1:0] instr_cnt_ff;
  reg  [3:0] pre_cnt_ff;
  wire       instr_tick;
  reg  [3:0] limit;

  // Quarter rate; free running like the core clock
  assign instr_tick = (instr_cnt_ff == `PMT_INSTR_DIV);

  always @* begin
    case (sel)
      `PMT_PRE_SEL_DIV1: limit = `PMT_PRE_DIV1;
      `PMT_PRE_SEL_DIV4: limit = `PMT_PRE_DIV4;
      default:           limit = `PMT_PRE_DIV16;
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      instr_cnt_ff <= 2'h0;
      pre_cnt_ff   <= 4'h0;
      tick_ff      <= 1'b0;
    end else if (clk_en) begin
      instr_cnt_ff <= instr_cnt_ff + 2'h1;
      tick_ff      <= 1'b0;
      if (clear) begin
        pre_cnt_ff <= 4'h0;
      end else if (run && instr_tick) begin
        if (pre_cnt_ff >= limit) begin
          pre_cnt_ff <= 4'h0;
          tick_ff    <= 1'b1;
        end else begin
          pre_cnt_ff <= pre_cnt_ff + 4'h1;
        end
      end
    end
  end
endmodule // pmt_prescaler

// file: rtl/pmt_timer.v
// Period match timer with APB register slave
// Function
// - Count clock is core clock divided by four through the prescaler
// - Prescale field bits 1:0: 00 is 1, 01 is 4, 1x is 16
// - Count rises from zero to period, then wraps to zero next tick
// - Each match advances postscaler; reaching ratio sets the event flag
// - Postscale field bits 6:3 gives field plus one matches per flag
// - Count and period read/write; reset to 00h and FFh
// - Control bit 2 starts and stops counting
// - Count or control writes and reset clear pre and postscaler
// - Control write leaves the count untouched
// - Control bit 7 reads zero, ignores writes; others reset zero
`include "pmt_defines.vh"
module pmt_timer (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         match_event_flag
);
  reg  [7:0] control_ff;
  reg  [7:0] count_ff;
  reg  [7:0] period_ff;
  reg  [3:0] post_cnt_ff;
  reg        flag_ff;
  reg        rsp_ff;
  reg        nxt_flag;
  reg  [7:0] nxt_count;
  reg  [3:0] nxt_post;
  reg [31:0] rd_mux;
  reg        rd_err;
  wire       tick;
  wire       setup;
  wire       wr_ctrl;
  wire       wr_count;
  wire       wr_flag;
  wire       sw_clear;
  wire       match;

  function is_addr;
    input [11:0] a;
    input [11:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  // Answer one cycle after setup: pready rises in first access cycle
  assign setup    = psel && !penable && !rsp_ff;
  assign wr_ctrl  = setup && pwrite && is_addr(paddr, `PMT_OFS_CONTROL);
  assign wr_count = setup && pwrite && is_addr(paddr, `PMT_OFS_COUNT);
  assign wr_flag  = setup && pwrite && is_addr(paddr, `PMT_OFS_FLAG);
  assign sw_clear = wr_ctrl || wr_count;
  assign match    = (count_ff == period_ff);

  pmt_prescaler u_pre (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .run      (control_ff[`PMT_RUN_BIT]),
    .clear    (sw_clear),
    .sel      (control_ff[`PMT_PS_HI:`PMT_PS_LO]),
    .tick_ff  (tick)
  );

  always @* begin
    nxt_count = count_ff;
    nxt_post  = post_cnt_ff;
    nxt_flag  = flag_ff;
    if (wr_flag && !pwdata[`PMT_FLAG_BIT])
      nxt_flag = 1'b0;
    if (tick && control_ff[`PMT_RUN_BIT]) begin
      if (match) begin
        nxt_count = `PMT_COUNT_RST;
        if (post_cnt_ff == control_ff[`PMT_POST_HI:`PMT_POST_LO]) begin
          nxt_post = 4'h0;
          nxt_flag = 1'b1;
        end else begin
          nxt_post = post_cnt_ff + 4'h1;
        end
      end else begin
        nxt_count = count_ff + 8'h01;
      end
    end
    if (sw_clear)
      nxt_post = 4'h0;
    if (wr_count)
      nxt_count = pwdata[7:0];
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `PMT_OFS_CONTROL: rd_mux[7:0] = control_ff;
      `PMT_OFS_COUNT:   rd_mux[7:0] = count_ff;
      `PMT_OFS_PERIOD:  rd_mux[7:0] = period_ff;
      `PMT_OFS_FLAG:    rd_mux[`PMT_FLAG_BIT] = flag_ff;
      default:          rd_err = 1'b1;
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_ff       <= `PMT_CTRL_RST;
      count_ff         <= `PMT_COUNT_RST;
      period_ff        <= `PMT_PERIOD_RST;
      post_cnt_ff      <= 4'h0;
      flag_ff          <= 1'b0;
      match_event_flag <= 1'b0;
      rsp_ff           <= 1'b0;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      prdata           <= 32'h0000_0000;
    end else if (clk_en) begin
      count_ff         <= nxt_count;
      post_cnt_ff      <= nxt_post;
      flag_ff          <= nxt_flag;
      match_event_flag <= nxt_flag;
      rsp_ff           <= setup;
      pready           <= setup;
      pslverr          <= setup && rd_err;
      prdata           <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      if (wr_ctrl)
        control_ff <= pwdata[7:0] & `PMT_CTRL_MASK;
      if (setup && pwrite && is_addr(paddr, `PMT_OFS_PERIOD))
        period_ff <= pwdata[7:0];
    end
  end
endmodule // pmt_timer

// file: testbench/pmt_timer_chk.sv
// Port assertions for the period timer
module pmt_timer_chk (
  input wire        core_clk,
  input wire        sys_rst,
  input wire        clk_en,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        match_event_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire clr = psel & ~penable & clk_en & pwrite & paddr == 12'h00c & ~pwdata[0];
  sequence s_set;
    psel && !penable && clk_en;
  endsequence
  sequence s_rd(a);
    psel && !penable && clk_en && !pwrite && paddr == a;
  endsequence
  property p_ans; s_set |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_idle; !pready |-> prdata == 0; endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_ctl; s_rd(12'h000) |=> prdata[31:7] == 0; endproperty
  a_ctl: assert property (p_ctl) else $error("bit 7 set");
  property p_cnt; s_rd(12'h004) |=> prdata[31:8] == 0 && !pslverr; endproperty
  a_cnt: assert property (p_cnt) else $error("bad count read");
  property p_map; s_set and (paddr > 12'h00c) |=> pslverr; endproperty
  a_map: assert property (p_map) else $error("no error");
  // Flag output falls only in the cycle after a flag write with bit 0 clear
  property p_hold; $fell(match_event_flag) |-> $past(clr); endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
endmodule // pmt_timer_chk

bind pmt_timer pmt_timer_chk pmt_timer_chk_i(.core_clk(core_clk),
  .sys_rst(sys_rst),.clk_en(clk_en),.psel(psel),.penable(penable),
  .pwrite(pwrite),.paddr(paddr),.pwdata(pwdata),.prdata(prdata),
  .pready(pready),.pslverr(pslverr),.match_event_flag(match_event_flag));

// file: testbench/test_pmt_timer.sv
// Register-level bench of the period timer
`include "pmt_defines.vh"
module test_pmt_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr;
  logic flg, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int fail_count, n_checks, cyc, t;
  int per[4] = '{2, 3, 1, 0};
  int n[4] = '{48, 16, 64, 16};
  logic [7:0] mc[4] = '{8'h7c, 8'h05, 8'h0e, 8'h07};
  pmt_timer pmt_timer_i(.core_clk(core_clk),.sys_rst(sys_rst),.clk_en(clk_en),
    .psel(psel),.penable(penable),.pwrite(pwrite),.paddr(paddr),
    .pwdata(pwdata),.prdata(prdata),.pready(pready),.pslverr(pslverr),
    .match_event_flag(flg));
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1;
    // Only the cycle ceiling bounds a wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    xf(0, a, 0);
    chk(rdat, e);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Run is well under 2000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      summarize;
    end
  end
  initial begin
    {sys_rst, clk_en, psel, penable, pwrite, paddr, pwdata} = {2'b11, 47'h0};
    repeat (5) @(posedge core_clk);
    sys_rst <= 0;
    rd(`PMT_OFS_CONTROL, 0);
    rd(`PMT_OFS_COUNT, 0);
    rd(`PMT_OFS_PERIOD, 32'hff);
    xf(1, `PMT_OFS_CONTROL, 32'hff);
    rd(`PMT_OFS_CONTROL, 32'h7f);
    xf(1, `PMT_OFS_CONTROL, 0);
    xf(1, `PMT_OFS_COUNT, 32'h5a);
    xf(1, `PMT_OFS_CONTROL, 32'h78);
    rd(`PMT_OFS_COUNT, 32'h5a);
    xf(1, `PMT_OFS_PERIOD, 32'h3c);
    rd(`PMT_OFS_PERIOD, 32'h3c);
    rd(12'h010, 0);
    chk({31'b0, rerr}, 1);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      xf(1, `PMT_OFS_CONTROL, 0);
      xf(1, `PMT_OFS_PERIOD, per[i]);
      xf(1, `PMT_OFS_COUNT, 0);
      xf(1, `PMT_OFS_FLAG, 0);
      xf(1, `PMT_OFS_CONTROL, mc[i]);
      t = 0;
      while (flg !== 1'b1 && t < 2000) begin
        @(posedge core_clk);
        t++;
      end
      // Divider phase and pipeline give a few cycles of slack
      chk({31'b0, t > 4 * n[i] - 8 && t < 4 * n[i] + 8}, 1);
      $display("timing case %0d done", i);
    end
    xf(1, `PMT_OFS_CONTROL, 0);
    xf(1, `PMT_OFS_FLAG, 1);
    rd(`PMT_OFS_FLAG, 1);
    xf(1, `PMT_OFS_FLAG, 0);
    rd(`PMT_OFS_FLAG, 0);
    $display("flag done");
    summarize;
  end
endmodule // test_pmt_timer
